// file: verilog/pmcs_pkg.sv
// Purpose: Constants for the power mode and clock source controller
// Assumes: APB slave, 32-bit data, one word per register
// Notes: Oscillator clocks are modelled as ready levels and half-cycle ticks
package pmcs_pkg;
  localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;   // osc_control_reg
  localparam logic [11:0] TMR_CTRL_ADDR = 12'h004;   // timer_osc_control_reg
  localparam logic [11:0] SLEEP_CMD_ADDR = 12'h008;  // Low-power instruction strobe
  // osc_control_reg fields
  localparam int IDLE_BIT = 7;
  localparam int FREQ_LSB = 4;
  localparam int FREQ_MSB = 6;
  localparam int INT_STABLE_BIT = 2;
  localparam int PRIMARY_RUN_MODE_BIT = 3;
  localparam int SRC_LSB = 0;
  localparam int SRC_MSB = 1;
  // timer_osc_control_reg fields
  localparam int TMR_EN_BIT = 3;
  localparam int SECONDARY_RUN_MODE_BIT = 6;
  localparam logic [2:0] FREQ_RESET = 3'h3;
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  // Five half cycles make two and a half cycles of each source
  localparam logic [2:0] HALF_CYCLES = 3'h5;
  typedef enum logic [1:0] {
    PMCS_CLK_PRI = 2'b00,
    PMCS_CLK_SEC = 2'b01,
    PMCS_CLK_INT = 2'b10
  } pmcs_clk_type;
  typedef enum logic [2:0] {
    PMCS_RUN = 3'b000,
    PMCS_WAIT_NEW = 3'b001,
    PMCS_OLD_HALF = 3'b010,
    PMCS_NEW_HALF = 3'b011,
    PMCS_SLEEP = 3'b100
  } pmcs_state_type;
endpackage : pmcs_pkg

// file: verilog/pmcs_ctrl.sv
// Purpose: Power-managed mode sequencer and system clock source select
// Assumes: Oscillator ready levels and half-cycle ticks arrive synchronous to pclk
// Notes: Clock gating and mux cells sit outside; this block drives their selects
`timescale 1ns/1ps
module pmcs_ctrl (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic wake, // Wake event from Sleep or Idle
  input wire logic two_speed_en, // Two-speed start-up enabled
  input wire logic primary_is_internal, // Primary configured as internal block
  input wire logic pri_ready, // Primary oscillator started
  input wire logic sec_ready, // Timer oscillator started
  input wire logic int_fast_stable, // Internal fast oscillator stable
  input wire logic int_fast_sel, // Internal mux output is the fast path
  input wire logic old_half_tick, // Half cycle of the old source
  input wire logic new_half_tick, // Half cycle of the new source
  output logic [1:0] clk_sel, // Active source for the glitch-free mux
  output logic cpu_clk_en, // CPU clock gate
  output logic periph_clk_en, // Peripheral clock gate
  output logic pri_osc_en, // Primary oscillator enable
  output logic sec_osc_en, // Timer oscillator enable
  output logic int_osc_en, // Internal block enable
  output logic [2:0] internal_freq_select, // Internal speed select
  output logic primary_running_flag, // Primary-running status
  output logic internal_stable_flag, // Internal-stable status
  output logic secondary_running_flag // Secondary-running status
);
  typedef struct packed {
    pmcs_pkg::pmcs_state_type st;
    logic [1:0] clock_source_select;
    logic idle_select;
    logic [2:0] freq;
    logic timer_osc_enable;
    pmcs_pkg::pmcs_clk_type cur;
    pmcs_pkg::pmcs_clk_type tgt;
    logic [2:0] cnt;
    logic idle;
    logic rst_hold;
    logic [31:0] rdata;
  } pmcs_regs_type;

  pmcs_regs_type r_q;
  pmcs_regs_type r_d;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic tgt_ready;
  pmcs_pkg::pmcs_clk_type want;

  function automatic pmcs_pkg::pmcs_clk_type decode_src(input logic [1:0] s);
    if (s[pmcs_pkg::SRC_MSB]) begin
      return pmcs_pkg::PMCS_CLK_INT;
    end
    return (s == pmcs_pkg::SRC_SECONDARY) ? pmcs_pkg::PMCS_CLK_SEC
                                          : pmcs_pkg::PMCS_CLK_PRI;
  endfunction : decode_src

  function automatic logic src_ready(input pmcs_pkg::pmcs_clk_type c, input logic ten,
                                     input logic pr, input logic sr);
    unique case (c)
      pmcs_pkg::PMCS_CLK_PRI: return pr;
      pmcs_pkg::PMCS_CLK_SEC: return ten & sr;
      default: return 1'b1;
    endcase
  endfunction : src_ready

  assign pready = 1'b1;
  assign mapped = (paddr == pmcs_pkg::OSC_CTRL_ADDR) || (paddr == pmcs_pkg::TMR_CTRL_ADDR) ||
                  (paddr == pmcs_pkg::SLEEP_CMD_ADDR);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_en = psel & ~penable & ~pwrite;
  assign prdata = r_q.rdata;
  assign want = decode_src(r_q.clock_source_select);
  assign tgt_ready = src_ready(r_q.tgt, r_q.timer_osc_enable, pri_ready, sec_ready);

  always_comb begin
    r_d = r_q;
    r_d.rst_hold = 1'b0;
    // Two-speed start runs from the internal block until the primary is up
    if (r_q.rst_hold && two_speed_en) begin
      r_d.cur = pmcs_pkg::PMCS_CLK_INT;
      r_d.tgt = pmcs_pkg::PMCS_CLK_PRI;
      r_d.st = pmcs_pkg::PMCS_WAIT_NEW;
    end
    if (wr_en && paddr == pmcs_pkg::OSC_CTRL_ADDR) begin
      r_d.idle_select = pwdata[pmcs_pkg::IDLE_BIT];
      r_d.freq = pwdata[pmcs_pkg::FREQ_MSB:pmcs_pkg::FREQ_LSB];
      r_d.clock_source_select = pwdata[pmcs_pkg::SRC_MSB:pmcs_pkg::SRC_LSB];
    end
    if (wr_en && paddr == pmcs_pkg::TMR_CTRL_ADDR) begin
      r_d.timer_osc_enable = pwdata[pmcs_pkg::TMR_EN_BIT];
    end
    unique case (r_q.st)
      pmcs_pkg::PMCS_RUN: begin
        // Any mismatch starts a switch, even internal-as-primary
        if (want != r_q.cur && !r_q.rst_hold) begin
          r_d.tgt = want;
          r_d.st = pmcs_pkg::PMCS_WAIT_NEW;
        end
        if (wr_en && paddr == pmcs_pkg::SLEEP_CMD_ADDR) begin
          if (r_q.idle_select) begin
            r_d.idle = 1'b1;
          end else begin
            r_d.st = pmcs_pkg::PMCS_SLEEP;
          end
        end
        if (r_q.idle && wake) begin
          r_d.idle = 1'b0;
        end
      end
      pmcs_pkg::PMCS_WAIT_NEW: begin
        // Old source keeps clocking while the new one starts
        if (want != r_q.tgt && !(r_q.rst_hold || two_speed_en && r_q.tgt ==
            pmcs_pkg::PMCS_CLK_PRI && want == pmcs_pkg::PMCS_CLK_PRI)) begin
          r_d.tgt = want;
        end
        if (tgt_ready) begin
          r_d.cnt = '0;
          r_d.st = pmcs_pkg::PMCS_OLD_HALF;
        end
      end
      pmcs_pkg::PMCS_OLD_HALF: begin
        if (old_half_tick) begin
          r_d.cnt = 3'(r_q.cnt + 3'h1);
          if (3'(r_q.cnt + 3'h1) == pmcs_pkg::HALF_CYCLES) begin
            r_d.cnt = '0;
            r_d.st = pmcs_pkg::PMCS_NEW_HALF;
          end
        end
      end
      pmcs_pkg::PMCS_NEW_HALF: begin
        if (new_half_tick) begin
          r_d.cnt = 3'(r_q.cnt + 3'h1);
          if (3'(r_q.cnt + 3'h1) == pmcs_pkg::HALF_CYCLES) begin
            r_d.cnt = '0;
            r_d.cur = r_q.tgt;
            r_d.st = pmcs_pkg::PMCS_RUN;
          end
        end
      end
      pmcs_pkg::PMCS_SLEEP: begin
        // Wake leaves idle and source fields as they were
        if (wake) begin
          r_d.tgt = want;
          r_d.st = pmcs_pkg::PMCS_WAIT_NEW;
        end
      end
      default: r_d.st = pmcs_pkg::PMCS_RUN;
    endcase
    if (rd_en) begin
      r_d.rdata = '0;
      if (paddr == pmcs_pkg::OSC_CTRL_ADDR) begin
        r_d.rdata[pmcs_pkg::IDLE_BIT] = r_q.idle_select;
        r_d.rdata[pmcs_pkg::FREQ_MSB:pmcs_pkg::FREQ_LSB] = r_q.freq;
        r_d.rdata[pmcs_pkg::PRIMARY_RUN_MODE_BIT] = primary_running_flag;
        r_d.rdata[pmcs_pkg::INT_STABLE_BIT] = internal_stable_flag;
        r_d.rdata[pmcs_pkg::SRC_MSB:pmcs_pkg::SRC_LSB] = r_q.clock_source_select;
      end else if (paddr == pmcs_pkg::TMR_CTRL_ADDR) begin
        r_d.rdata[pmcs_pkg::TMR_EN_BIT] = r_q.timer_osc_enable;
        r_d.rdata[pmcs_pkg::SECONDARY_RUN_MODE_BIT] = secondary_running_flag;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q.st <= pmcs_pkg::PMCS_RUN;
      r_q.clock_source_select <= pmcs_pkg::SRC_PRIMARY;
      r_q.idle_select <= 1'b0;
      r_q.freq <= pmcs_pkg::FREQ_RESET;
      r_q.timer_osc_enable <= 1'b0;
      r_q.cur <= pmcs_pkg::PMCS_CLK_PRI;
      r_q.tgt <= pmcs_pkg::PMCS_CLK_PRI;
      r_q.cnt <= '0;
      r_q.idle <= 1'b0;
      r_q.rst_hold <= 1'b1;
      r_q.rdata <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  logic asleep;
  logic fast_ok;
  assign asleep = (r_q.st == pmcs_pkg::PMCS_SLEEP);
  assign fast_ok = int_fast_sel & int_fast_stable;
  assign clk_sel = r_q.cur;
  assign internal_freq_select = r_q.freq;
  assign cpu_clk_en = ~asleep & ~r_q.idle;
  assign periph_clk_en = ~asleep;
  // Primary is powered while active or being started
  assign pri_osc_en = ~asleep & (r_q.cur == pmcs_pkg::PMCS_CLK_PRI ||
                      r_q.tgt == pmcs_pkg::PMCS_CLK_PRI);
  assign sec_osc_en = r_q.timer_osc_enable;
  assign int_osc_en = ~asleep & (r_q.cur == pmcs_pkg::PMCS_CLK_INT ||
                      r_q.tgt == pmcs_pkg::PMCS_CLK_INT || primary_is_internal);
  // Flags follow the settled source only, so they swap at switch end
  assign primary_running_flag = ~asleep & (r_q.cur == pmcs_pkg::PMCS_CLK_PRI) &
                                (~primary_is_internal | fast_ok);
  assign internal_stable_flag = ~asleep & fast_ok & ((r_q.cur == pmcs_pkg::PMCS_CLK_INT) |
                                (r_q.cur == pmcs_pkg::PMCS_CLK_PRI &
                                primary_is_internal));
  assign secondary_running_flag = ~asleep & (r_q.cur == pmcs_pkg::PMCS_CLK_SEC);

  property p_sleep_flags;
    @(posedge pclk) disable iff (!presetn)
      asleep |-> !primary_running_flag && !internal_stable_flag && !secondary_running_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("flags set in sleep");

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st == pmcs_pkg::PMCS_RUN && wr_en && paddr == pmcs_pkg::SLEEP_CMD_ADDR &&
       !r_q.idle_select) |=> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep left clocks on");

  property p_idle_entry;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st == pmcs_pkg::PMCS_RUN && wr_en && paddr == pmcs_pkg::SLEEP_CMD_ADDR &&
       r_q.idle_select) |=> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle gating wrong");

  property p_only_by_cmd;
    @(posedge pclk) disable iff (!presetn)
      $rose(asleep) |-> $past(wr_en) && $past(paddr) == pmcs_pkg::SLEEP_CMD_ADDR;
  endproperty
  a_only_by_cmd: assert property (p_only_by_cmd) else $error("sleep without command");

  sequence s_old_done;
    r_q.st == pmcs_pkg::PMCS_OLD_HALF && old_half_tick &&
      r_q.cnt == 3'(pmcs_pkg::HALF_CYCLES - 3'h1);
  endsequence
  property p_old_half;
    @(posedge pclk) disable iff (!presetn)
      s_old_done |=> r_q.st == pmcs_pkg::PMCS_NEW_HALF && r_q.cnt == 3'h0;
  endproperty
  a_old_half: assert property (p_old_half) else $error("old half count wrong");

  property p_sec_defer;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st == pmcs_pkg::PMCS_WAIT_NEW && r_q.tgt == pmcs_pkg::PMCS_CLK_SEC &&
       !r_q.timer_osc_enable) |=> r_q.st != pmcs_pkg::PMCS_OLD_HALF;
  endproperty
  a_sec_defer: assert property (p_sec_defer) else $error("secondary not deferred");

  property p_sec_flags;
    @(posedge pclk) disable iff (!presetn)
      secondary_running_flag |-> !primary_running_flag && !pri_osc_en ||
        r_q.tgt == pmcs_pkg::PMCS_CLK_PRI;
  endproperty
  a_sec_flags: assert property (p_sec_flags) else $error("secondary flags wrong");

  property p_sel_stable;
    @(posedge pclk) disable iff (!presetn)
      r_q.st == pmcs_pkg::PMCS_WAIT_NEW |=> $stable(clk_sel);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select moved early");

  property p_timer_en;
    @(posedge pclk) disable iff (!presetn)
      r_q.timer_osc_enable |-> sec_osc_en;
  endproperty
  a_timer_en: assert property (p_timer_en) else $error("timer osc stopped");

  // Checks the write path, not just the wire to the enable output
  property p_timer_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == pmcs_pkg::TMR_CTRL_ADDR) |=>
        sec_osc_en == $past(pwdata[pmcs_pkg::TMR_EN_BIT]);
  endproperty
  a_timer_wr: assert property (p_timer_wr) else $error("timer enable not applied");

  sequence s_new_done;
    r_q.st == pmcs_pkg::PMCS_NEW_HALF && new_half_tick &&
      r_q.cnt == 3'(pmcs_pkg::HALF_CYCLES - 3'h1);
  endsequence
  property p_new_half;
    @(posedge pclk) disable iff (!presetn)
      s_new_done |=> r_q.st == pmcs_pkg::PMCS_RUN && clk_sel == $past(r_q.tgt);
  endproperty
  a_new_half: assert property (p_new_half) else $error("switch end wrong");

  property p_flag_code;
    @(posedge pclk) disable iff (!presetn)
      secondary_running_flag |-> !primary_running_flag && !internal_stable_flag;
  endproperty
  a_flag_code: assert property (p_flag_code) else $error("illegal flag code");

  property p_slow_int;
    @(posedge pclk) disable iff (!presetn)
      (clk_sel == pmcs_pkg::PMCS_CLK_INT && !fast_ok) |->
        !primary_running_flag && !internal_stable_flag && !secondary_running_flag;
  endproperty
  a_slow_int: assert property (p_slow_int) else $error("flags set on slow clock");

  // First cycle after reset picks the start-up source
  property p_two_speed;
    @(posedge pclk) disable iff (!presetn)
      r_q.rst_hold |=> clk_sel == ($past(two_speed_en) ? pmcs_pkg::PMCS_CLK_INT :
                                   pmcs_pkg::PMCS_CLK_PRI);
  endproperty
  a_two_speed: assert property (p_two_speed) else $error("reset source wrong");

  property p_int_pri_off;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st == pmcs_pkg::PMCS_RUN && clk_sel == pmcs_pkg::PMCS_CLK_INT) |->
        !pri_osc_en && !primary_running_flag;
  endproperty
  a_int_pri_off: assert property (p_int_pri_off) else $error("primary still on");

  property p_idle_periph;
    @(posedge pclk) disable iff (!presetn)
      r_q.idle |-> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle clocks wrong");

  property p_freq_now;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == pmcs_pkg::OSC_CTRL_ADDR) |=>
        internal_freq_select == $past(pwdata[pmcs_pkg::FREQ_MSB:pmcs_pkg::FREQ_LSB]);
  endproperty
  a_freq_now: assert property (p_freq_now) else $error("speed select late");
endmodule : pmcs_ctrl

// file: tb/pmcs_cpu_model.sv
// Purpose: CPU core stand-in giving register writes and the low-power instruction
// Assumes: APB master; the slave may insert wait states
// Notes: All bus signals change just after a rising pclk edge
`timescale 1ns/1ps
module pmcs_cpu_model (
  input wire logic pclk, // Bus clock
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Byte address
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait states end when pready goes high; a slave that never raises it ends at the bench timeout
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like a held value
    pwdata <= ~wd;
  endtask : xfer
  // Mode taken from the idle bit written before this call
  task automatic sleep_cmd();
    logic [31:0] d;
    logic e;
    xfer(1'b1, pmcs_pkg::SLEEP_CMD_ADDR, 32'h0, d, e);
  endtask : sleep_cmd
endmodule : pmcs_cpu_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the power mode and clock source controller
// Assumes: Zero-wait APB slave; oscillator readiness driven by the bench
// Notes: Half-cycle ticks are random, so switch times are lower bounds only
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, wake, pri_ready, sec_ready;
  logic int_fast_stable, old_half_tick, new_half_tick, cpu_clk_en, periph_clk_en;
  logic pri_osc_en, sec_osc_en, int_osc_en, pri_f, int_f, sec_f, err;
  logic two_speed_en, primary_is_internal, int_fast_sel;
  logic [1:0] clk_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] f, freq_o;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  always #25 pclk = ~pclk;
  pmcs_ctrl pmcs_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake(wake), .two_speed_en(two_speed_en),
    .primary_is_internal(primary_is_internal), .pri_ready(pri_ready),
    .sec_ready(sec_ready), .int_fast_stable(int_fast_stable),
    .int_fast_sel(int_fast_sel), .old_half_tick(old_half_tick), .new_half_tick(new_half_tick),
    .clk_sel(clk_sel), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .pri_osc_en(pri_osc_en), .sec_osc_en(sec_osc_en), .int_osc_en(int_osc_en),
    .internal_freq_select(freq_o), .primary_running_flag(pri_f),
    .internal_stable_flag(int_f), .secondary_running_flag(sec_f));
  pmcs_cpu_model pmcs_cpu_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  function automatic logic [31:0] exp_flags(logic [1:0] s, logic st);
    if (s == pmcs_pkg::SRC_PRIMARY) return 32'h4;
    if (s == pmcs_pkg::SRC_SECONDARY) return 32'h1;
    return st ? 32'h2 : 32'h0;
  endfunction : exp_flags
  function automatic logic [31:0] osc_word(logic i, logic [2:0] fr, logic [1:0] s);
    return {24'h0, i, fr, 2'b10, s};
  endfunction : osc_word
  function automatic logic [31:0] flags_now();
    return {29'h0, pri_f, int_f, sec_f};
  endfunction : flags_now
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    pmcs_cpu_model_i.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    pmcs_cpu_model_i.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdr
  // Waits for the select, the CPU clock and the flags of a settled run mode
  task automatic wait_sel(input logic [1:0] s);
    n = 0;
    while (({clk_sel, cpu_clk_en} !== {s, 1'b1} || flags_now() !== exp_flags(s, 1'b1))
           && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("settled sel", {30'h0, s}, {30'h0, clk_sel});
    chk("settle limit", 32'h1, {31'h0, n < 2000});
  endtask : wait_sel
  task automatic to_primary(input logic [1:0] from);
    pri_ready <= 1'b0;
    wr(pmcs_pkg::OSC_CTRL_ADDR, {25'h0, f, 4'h0});
    repeat (20) @(posedge pclk);
    chk("held source", {30'h0, from}, {30'h0, clk_sel});
    pri_ready <= 1'b1;
    wait_sel(pmcs_pkg::SRC_PRIMARY);
    chk("primary flags", 32'h4, flags_now());
  endtask : to_primary
  task automatic wake_up();
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    // Wake from sleep restarts a switch to the same source, invisible on the select
    repeat (200) @(posedge pclk);
    wait_sel(pmcs_pkg::SRC_PRIMARY);
  endtask : wake_up
  always @(posedge pclk) begin
    old_half_tick <= 1'($urandom_range(1, 0));
    new_half_tick <= 1'($urandom_range(1, 0));
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {presetn, wake, sec_ready, int_fast_stable, two_speed_en, primary_is_internal} = 6'h0;
    int_fast_sel = 1'b1;
    pri_ready = 1'b1;
    f = pmcs_pkg::FREQ_RESET;
    void'($urandom(17));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset flags", 32'h4, flags_now());
    rdr(pmcs_pkg::OSC_CTRL_ADDR);
    chk("reset word", osc_word(1'b0, f, 2'h0), rd);
    chk("reset speed", {29'h0, f}, {29'h0, freq_o});
    // Timer enable still clear, so the switch must wait
    wr(pmcs_pkg::OSC_CTRL_ADDR, {25'h0, f, 2'b00, pmcs_pkg::SRC_SECONDARY});
    repeat (30) @(posedge pclk);
    chk("deferred", 32'h0, {30'h0, clk_sel});
    sec_ready <= 1'b1;
    wr(pmcs_pkg::TMR_CTRL_ADDR, 32'h8);
    wait_sel(pmcs_pkg::SRC_SECONDARY);
    chk("sec time", 32'h1, {31'h0, n >= 10});
    chk("sec flags", 32'h1, flags_now());
    chk("osc enables", 32'h1, {30'h0, pri_osc_en, sec_osc_en});
    to_primary(pmcs_pkg::SRC_SECONDARY);
    chk("timer kept", 32'h1, {31'h0, sec_osc_en});
    // Internal block as primary: no flag until it is stable, then two flags
    primary_is_internal <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("int primary unstable", 32'h0, flags_now());
    int_fast_stable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("int primary", 32'h6, flags_now());
    primary_is_internal <= 1'b0;
    for (int s = 2; s < 4; s++) begin
      int_fast_stable <= 1'b1;
      f = 3'($urandom_range(7, 0));
      // Low bit set on the second pass on purpose
      wr(pmcs_pkg::OSC_CTRL_ADDR, {25'h0, f, 2'b00, 2'(s)});
      wait_sel(2'h2);
      chk("int time", 32'h1, {31'h0, n >= 10});
      chk("int flags", exp_flags(2'(s), 1'b1), flags_now());
      chk("pri off", 32'h1, {30'h0, pri_osc_en, int_osc_en});
      // Unstable fast path on one pass, slow oscillator on the other
      if (s == 2) begin
        int_fast_stable <= 1'b0;
      end else begin
        int_fast_sel <= 1'b0;
      end
      repeat (2) @(posedge pclk);
      chk("unstable", 32'h0, flags_now());
      int_fast_stable <= 1'b1;
      int_fast_sel <= 1'b1;
      f = ~f;
      wr(pmcs_pkg::OSC_CTRL_ADDR, {25'h0, f, 2'b00, 2'(s)});
      @(posedge pclk);
      chk("speed out", {29'h0, f}, {29'h0, freq_o});
      rdr(pmcs_pkg::OSC_CTRL_ADDR);
      chk("freq", {29'h0, f}, {29'h0, rd[6:4]});
      to_primary(2'h2);
    end
    pmcs_cpu_model_i.sleep_cmd();
    repeat (2) @(posedge pclk);
    chk("sleep gates", 32'h0, {30'h0, cpu_clk_en, periph_clk_en});
    chk("sleep flags", 32'h0, flags_now());
    chk("sleep oscs", 32'h1, {29'h0, pri_osc_en, int_osc_en, sec_osc_en});
    wake_up();
    rdr(pmcs_pkg::OSC_CTRL_ADDR);
    chk("sleep keep", osc_word(1'b0, f, 2'h0), rd);
    wr(pmcs_pkg::OSC_CTRL_ADDR, {24'h0, 1'b1, f, 4'h0});
    pmcs_cpu_model_i.sleep_cmd();
    repeat (2) @(posedge pclk);
    chk("idle gates", 32'h1, {30'h0, cpu_clk_en, periph_clk_en});
    chk("idle flags", 32'h4, flags_now());
    wake_up();
    rdr(pmcs_pkg::OSC_CTRL_ADDR);
    chk("idle keep", osc_word(1'b1, f, 2'h0), rd);
    // Second reset with two-speed start: internal clock until primary is up
    two_speed_en <= 1'b1;
    pri_ready <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("two-speed sel", 32'h2, {30'h0, clk_sel});
    chk("two-speed flags", 32'h2, flags_now());
    pri_ready <= 1'b1;
    wait_sel(pmcs_pkg::SRC_PRIMARY);
    two_speed_en <= 1'b0;
    rdr(12'h00c);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    conclude();
  end
endmodule : tb_top
